// ---- hw/comp_regs_pkg.sv ----
// constants, field layouts and carrier types of the comparator register bank
package comp_regs_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int SEL_W  = 4;
    localparam int NUM_EVENTS = 4;
    localparam int NUM_LINKS  = 5;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFF_READY_FLAG  = 12'h100;
    localparam logic [ADDR_W-1:0] OFF_FALL_FLAG   = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_RISE_FLAG   = 12'h108;
    localparam logic [ADDR_W-1:0] OFF_ANY_FLAG    = 12'h10C;
    localparam logic [ADDR_W-1:0] OFF_LINKS       = 12'h200;
    localparam logic [ADDR_W-1:0] OFF_MASK        = 12'h300;
    localparam logic [ADDR_W-1:0] OFF_SETTER      = 12'h304;
    localparam logic [ADDR_W-1:0] OFF_CLEARER     = 12'h308;
    localparam logic [ADDR_W-1:0] OFF_EVENT_STAT  = 12'h310;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int FLAG_BIT = 0;
    // event bit order in mask, setter, clearer and status alias
    localparam int EV_VALID = 0;
    localparam int EV_FALL  = 1;
    localparam int EV_RISE  = 2;
    localparam int EV_ANY   = 3;
    // shortcut fields
    localparam int LINK_VALID_CAPTURE = 0;
    localparam int LINK_VALID_HALT    = 1;
    localparam int LINK_FALL_HALT     = 2;
    localparam int LINK_RISE_HALT     = 3;
    localparam int LINK_ANY_HALT      = 4;
    localparam int SEL_LOW_BYTE       = 0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [DATA_W-1:0]     RESET_WORD  = 32'h00000000;
    localparam logic [NUM_LINKS-1:0]  RESET_LINKS = 5'h00;
    localparam logic [NUM_EVENTS-1:0] RESET_MASK  = 4'h0;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [ADDR_W-1:0] adr;
        logic [SEL_W-1:0]  sel;
        logic [DATA_W-1:0] dat;
    } wb_req_type;

    typedef struct packed {
        logic              ack;
        logic [DATA_W-1:0] dat;
    } wb_rsp_type;

    typedef struct packed {
        logic capture;
        logic halt;
    } task_type;

endpackage

// ---- hw/event_flag.sv ----
// one sticky event flag with software write and write-one-to-clear alias
module event_flag (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic event_pulse,
    input  wire logic write_en,
    input  wire logic write_value,
    input  wire logic clear_one,
    output logic      flag
);

    typedef struct packed {
        logic flag;
    } flag_state_type;

    flag_state_type state;
    flag_state_type next_state;

    always_comb begin
        next_state = state;
        if (write_en) begin
            next_state.flag = write_value;
        end
        if (clear_one) begin
            next_state.flag = 1'b0;
        end
        // a new event beats a clear in the same cycle
        if (event_pulse) begin
            next_state.flag = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flag = state.flag;

endmodule

// ---- hw/task_link.sv ----
// gated event-to-task trigger, registered one-cycle pulse out
module task_link #(
    parameter int N = 1
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] events,
    input  wire logic [N-1:0] links,
    output logic              trigger
);

    typedef struct packed {
        logic trigger;
    } link_state_type;

    link_state_type state;
    link_state_type next_state;

    always_comb begin
        next_state = state;
        // a cleared link field drops its event
        next_state.trigger = |(events & links);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign trigger = state.trigger;

endmodule

// ---- hw/comparator_event_irq_regs.sv ----
// comparator event flags, shortcuts and interrupt enables on wishbone
// ********************************************************************
// What this block does
// - rise and any-transition flags in bit 0, readable, writable, reset 0
// - link A set: valid event fires capture task by itself
// - link B set: valid event fires the halt task
// - link C set: fall event fires the halt task
// - link D set: rise event fires the halt task
// - link E set: any-transition event halts; all links reset to 0
// - enable mask: one rw bit per event, 1 enables, reset 0
// - setter: writing 1 sets enable bit; reads return enable state
// - clearer: writing 1 clears enable bit; reads return enable state
// ********************************************************************
module comparator_event_irq_regs (
    input  wire logic                                        clock,
    input  wire logic                                        rst_n,
    input  wire comp_regs_pkg::wb_req_type                   wb_req,
    output comp_regs_pkg::wb_rsp_type                        wb_rsp,
    input  wire logic [comp_regs_pkg::NUM_EVENTS-1:0]        core_events,
    output comp_regs_pkg::task_type                          tasks,
    output logic                                             irq
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic                                   ack;
        logic [comp_regs_pkg::DATA_W-1:0]       dat;
        logic [comp_regs_pkg::NUM_LINKS-1:0]    links;
        logic [comp_regs_pkg::NUM_EVENTS-1:0]   mask;
        logic                                   irq;
    } regs_state_type;

    regs_state_type state;
    regs_state_type next_state;

    logic [comp_regs_pkg::NUM_EVENTS-1:0] flags;
    logic [comp_regs_pkg::NUM_EVENTS-1:0] flag_write;
    logic [comp_regs_pkg::NUM_EVENTS-1:0] flag_clear;
    logic                                 access;
    logic                                 write_low;
    logic [comp_regs_pkg::ADDR_W-1:0]     word_adr;
    logic [comp_regs_pkg::NUM_EVENTS-1:0] wr_bits;
    logic [3:0]                           halt_events;
    logic [3:0]                           halt_links;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    // answer in the cycle after the strobe, drop the cycle after that
    assign access    = wb_req.cyc & wb_req.stb & ~state.ack;
    // every field lives in the low byte, so only lane 0 carries writes
    assign write_low = access & wb_req.we
                     & wb_req.sel[comp_regs_pkg::SEL_LOW_BYTE];
    assign word_adr  = {wb_req.adr[comp_regs_pkg::ADDR_W-1:2], 2'b00};
    assign wr_bits   = wb_req.dat[comp_regs_pkg::NUM_EVENTS-1:0];

    always_comb begin
        flag_write = '0;
        flag_clear = '0;
        if (write_low) begin
            case (word_adr)
                comp_regs_pkg::OFF_READY_FLAG: begin
                    flag_write[comp_regs_pkg::EV_VALID] = 1'b1;
                end
                comp_regs_pkg::OFF_FALL_FLAG: begin
                    flag_write[comp_regs_pkg::EV_FALL] = 1'b1;
                end
                comp_regs_pkg::OFF_RISE_FLAG: begin
                    flag_write[comp_regs_pkg::EV_RISE] = 1'b1;
                end
                comp_regs_pkg::OFF_ANY_FLAG: begin
                    flag_write[comp_regs_pkg::EV_ANY] = 1'b1;
                end
                comp_regs_pkg::OFF_EVENT_STAT: begin
                    flag_clear = wr_bits;
                end
                default: begin
                    flag_clear = '0;
                end
            endcase
        end
    end

    // ****************************************************************
    // event flags
    // ****************************************************************
    // sticky flags per event
    for (genvar i = 0; i < comp_regs_pkg::NUM_EVENTS; i++) begin : g_flag
        event_flag u_flag (
            .clock       (clock),
            .rst_n       (rst_n),
            .event_pulse (core_events[i]),
            .write_en    (flag_write[i]),
            .write_value (wb_req.dat[comp_regs_pkg::FLAG_BIT]),
            .clear_one   (flag_clear[i]),
            .flag        (flags[i])
        );
    end

    // ****************************************************************
    // shortcuts
    // ****************************************************************
    // valid to capture
    task_link #(
        .N (1)
    ) u_capture (
        .clock   (clock),
        .rst_n   (rst_n),
        .events  (core_events[comp_regs_pkg::EV_VALID]),
        .links   (state.links[comp_regs_pkg::LINK_VALID_CAPTURE]),
        .trigger (tasks.capture)
    );

    assign halt_events = {core_events[comp_regs_pkg::EV_ANY],
                          core_events[comp_regs_pkg::EV_RISE],
                          core_events[comp_regs_pkg::EV_FALL],
                          core_events[comp_regs_pkg::EV_VALID]};
    assign halt_links  = {state.links[comp_regs_pkg::LINK_ANY_HALT],
                          state.links[comp_regs_pkg::LINK_RISE_HALT],
                          state.links[comp_regs_pkg::LINK_FALL_HALT],
                          state.links[comp_regs_pkg::LINK_VALID_HALT]};

    task_link #(
        .N (4)
    ) u_halt (
        .clock   (clock),
        .rst_n   (rst_n),
        .events  (halt_events),
        .links   (halt_links),
        .trigger (tasks.halt)
    );

    // ****************************************************************
    // registers and read path
    // ****************************************************************
    always_comb begin
        next_state     = state;
        next_state.ack = access;
        next_state.dat = comp_regs_pkg::RESET_WORD;
        if (write_low) begin
            case (word_adr)
                comp_regs_pkg::OFF_LINKS: begin
                    next_state.links =
                        wb_req.dat[comp_regs_pkg::NUM_LINKS-1:0];
                end
                comp_regs_pkg::OFF_MASK: begin
                    next_state.mask = wr_bits;
                end
                comp_regs_pkg::OFF_SETTER: begin
                    next_state.mask = state.mask | wr_bits;
                end
                comp_regs_pkg::OFF_CLEARER: begin
                    next_state.mask = state.mask & ~wr_bits;
                end
                default: begin
                    next_state.mask = state.mask;
                end
            endcase
        end
        if (access && !wb_req.we) begin
            case (word_adr)
                comp_regs_pkg::OFF_READY_FLAG: begin
                    next_state.dat[comp_regs_pkg::FLAG_BIT] =
                        flags[comp_regs_pkg::EV_VALID];
                end
                comp_regs_pkg::OFF_FALL_FLAG: begin
                    next_state.dat[comp_regs_pkg::FLAG_BIT] =
                        flags[comp_regs_pkg::EV_FALL];
                end
                comp_regs_pkg::OFF_RISE_FLAG: begin
                    next_state.dat[comp_regs_pkg::FLAG_BIT] =
                        flags[comp_regs_pkg::EV_RISE];
                end
                comp_regs_pkg::OFF_ANY_FLAG: begin
                    next_state.dat[comp_regs_pkg::FLAG_BIT] =
                        flags[comp_regs_pkg::EV_ANY];
                end
                comp_regs_pkg::OFF_LINKS: begin
                    next_state.dat[comp_regs_pkg::NUM_LINKS-1:0] =
                        state.links;
                end
                // all three aliases read the enables
                comp_regs_pkg::OFF_MASK,
                comp_regs_pkg::OFF_SETTER,
                comp_regs_pkg::OFF_CLEARER: begin
                    next_state.dat[comp_regs_pkg::NUM_EVENTS-1:0] =
                        state.mask;
                end
                comp_regs_pkg::OFF_EVENT_STAT: begin
                    next_state.dat[comp_regs_pkg::NUM_EVENTS-1:0] = flags;
                end
                // unmapped reads answer zero
                default: begin
                    next_state.dat = comp_regs_pkg::RESET_WORD;
                end
            endcase
        end
        // enabled flag drives irq
        // registered, so it trails the flag by one cycle
        next_state.irq = |(flags & state.mask);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state       <= '0;
            state.links <= comp_regs_pkg::RESET_LINKS;
            state.mask  <= comp_regs_pkg::RESET_MASK;
        end else begin
            state <= next_state;
        end
    end

    assign wb_rsp.ack = state.ack;
    assign wb_rsp.dat = state.dat;
    assign irq        = state.irq;

endmodule

// ---- tb/comparator_event_irq_regs_assertions.sv ----
// checker of the comparator register bank ports
// ****************
// shadow state and assertions
// ****************
module comparator_event_irq_regs_checker (
    input wire logic                      clock,
    input wire logic                      rst_n,
    input wire comp_regs_pkg::wb_req_type wb_req,
    input wire comp_regs_pkg::wb_rsp_type wb_rsp,
    input wire logic [3:0]                core_events,
    input wire comp_regs_pkg::task_type   tasks,
    input wire logic                      irq
);
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [3:0] flag;
        logic [3:0] mask;
        logic [4:0] link;
    } shadow_type;
    shadow_type sh;
    shadow_type next_sh;
    logic       take;
    logic       wr;
    logic       rd;
    logic       cause;
    logic       irq_cause;
    logic       cap_cause;
    logic [3:0] wd;
    assign take      = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
    assign wr        = take & wb_req.we & wb_req.sel[0];
    assign rd        = take & ~wb_req.we;
    assign wd        = wb_req.dat[3:0];
    assign cause     = |(core_events & sh.link[4:1]);
    assign irq_cause = |(sh.flag & sh.mask);
    assign cap_cause = core_events[0] & sh.link[0];
    // set wins over a clear in the same cycle
    always_comb begin
        next_sh = sh;
        for (int i = 0; i < 4; i++) begin
            if (wr && wb_req.adr == 12'h100 + 12'(4 * i)) begin
                next_sh.flag[i] = wb_req.dat[0];
            end
        end
        if (wr) begin
            case (wb_req.adr)
                12'h200: next_sh.link = wb_req.dat[4:0];
                12'h300: next_sh.mask = wd;
                12'h304: next_sh.mask = sh.mask | wd;
                12'h308: next_sh.mask = sh.mask & ~wd;
                12'h310: next_sh.flag = next_sh.flag & ~wd;
                default: ;
            endcase
        end
        next_sh.flag = next_sh.flag | core_events;
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sh <= 13'h0000;
        end else begin
            sh <= next_sh;
        end
    end
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    a_ack_follows: assert property (take |=> wb_rsp.ack)
        else $error("request not answered next cycle");
    a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack longer than one cycle");
    a_halt_cause: assert property (cause |=> tasks.halt)
        else $error("linked event gave no halt");
    a_halt_quiet: assert property (!cause |=> !tasks.halt)
        else $error("halt without linked event");
    a_capture_link: assert property (
        1'b1 |=> tasks.capture == $past(cap_cause))
        else $error("capture does not follow link");
    a_irq_level: assert property (1'b1 |=> irq == $past(irq_cause))
        else $error("irq does not follow flags and mask");
    a_mask_read: assert property (
        rd && wb_req.adr inside {12'h300, 12'h304, 12'h308}
        |=> wb_rsp.dat == {28'h0000000, $past(sh.mask)})
        else $error("mask read wrong");
    a_flag_read: assert property (
        rd && wb_req.adr == 12'h108 |=> wb_rsp.dat[0] == $past(sh.flag[2]))
        else $error("rise flag read wrong");
    cover property (tasks.halt);
    cover property (tasks.capture);
    cover property (irq);
endmodule

bind comparator_event_irq_regs comparator_event_irq_regs_checker chk (
    .clock(clock), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .core_events(core_events), .tasks(tasks), .irq(irq)
);

// ---- tb/test_comparator_event_irq_regs.sv ----
// self-checking bench of the comparator register bank
module test_comparator_event_irq_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic                      clock = 1'b0;
    logic                      rst_n = 1'b0;
    comp_regs_pkg::wb_req_type wb_req = '{default: 1'b0};
    comp_regs_pkg::wb_rsp_type wb_rsp;
    logic [3:0]                core_events = 4'h0;
    comp_regs_pkg::task_type   tasks;
    logic                      irq;
    logic [31:0]               rdat;
    int                        failures = 0;
    int                        compares = 0;
    int                        cycles = 0;

    comparator_event_irq_regs dut (
        .clock      (clock),
        .rst_n      (rst_n),
        .wb_req     (wb_req),
        .wb_rsp     (wb_rsp),
        .core_events(core_events),
        .tasks      (tasks),
        .irq        (irq)
    );

    always #2 clock = ~clock;

    // a hang ends the run as a failure
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // held until ack is seen at a rising edge; no cycle count assumed
    task automatic wb(input logic we, input logic [11:0] adr,
                      input logic [31:0] dat, input logic [3:0] sel);
        @(posedge clock);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel,
                    dat: dat};
        @(posedge clock);
        while (wb_rsp.ack !== 1'b1) begin
            @(posedge clock);
        end
        // read data taken at the same edge that sees ack
        rdat = wb_rsp.dat;
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
        wb(1'b1, adr, dat, 4'hF);
    endtask

    task automatic rd(input logic [11:0] adr);
        wb(1'b0, adr, 32'h00000000, 4'hF);
    endtask

    task automatic pulse(input logic [3:0] ev);
        @(posedge clock);
        core_events <= ev;
        @(posedge clock);
        core_events <= 4'h0;
    endtask

    task automatic t_reset_values();
        logic [11:0] offs [9] = '{12'h100, 12'h104, 12'h108, 12'h10C,
                                  12'h200, 12'h300, 12'h304, 12'h308,
                                  12'h310};
        foreach (offs[i]) begin
            rd(offs[i]);
            check("reset value", rdat, 32'h00000000);
        end
    endtask

    task automatic t_flags();
        logic [11:0] offs [2] = '{12'h108, 12'h10C};
        foreach (offs[i]) begin
            wr(offs[i], 32'hFFFFFFFF);
            rd(offs[i]);
            check("flag one", rdat, 32'h00000001);
            wb(1'b1, offs[i], 32'h00000000, 4'h0);
            rd(offs[i]);
            check("flag kept", rdat, 32'h00000001);
            wr(offs[i], 32'h00000000);
            rd(offs[i]);
            check("flag zero", rdat, 32'h00000000);
        end
        rd(12'h0F0);
        check("unmapped read", rdat, 32'h00000000);
    endtask

    // every link against every event
    task automatic t_links();
        for (int k = 0; k < 5; k++) begin
            wr(12'h200, 32'h00000001 << k);
            for (int j = 0; j < 4; j++) begin
                pulse(4'h1 << j);
                #1;
                check("halt", tasks.halt, k == j + 1);
                check("capture", tasks.capture, k == 0 && j == 0);
            end
        end
        wr(12'h200, 32'h00000000);
    endtask

    task automatic t_mask();
        wr(12'h300, 32'hFFFFFFF5);
        rd(12'h304);
        check("setter read", rdat, 32'h00000005);
        wr(12'h304, 32'h00000002);
        rd(12'h300);
        check("setter ones only", rdat, 32'h00000007);
        wr(12'h308, 32'h00000001);
        rd(12'h308);
        check("clearer", rdat, 32'h00000006);
    endtask

    // mask now enables fall and rise only
    task automatic t_irq();
        wr(12'h310, 32'h0000000F);
        pulse(4'h1);
        @(posedge clock);
        #1 check("irq masked", irq, 1'b0);
        pulse(4'h4);
        @(posedge clock);
        #1 check("irq raised", irq, 1'b1);
        rd(12'h310);
        check("event status", rdat, 32'h00000005);
        wr(12'h308, 32'h00000004);
        #1 check("irq disabled", irq, 1'b0);
        wr(12'h304, 32'h00000004);
        #1 check("irq enabled", irq, 1'b1);
        wr(12'h310, 32'h00000004);
        #1 check("irq cleared", irq, 1'b0);
    endtask

    // a reset in mid-run must wipe links, enables and flags
    task automatic t_mid_reset();
        wr(12'h200, 32'h0000001F);
        wr(12'h300, 32'h0000000F);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1 check("irq after reset", irq, 1'b0);
        rd(12'h200);
        check("links after reset", rdat, 32'h00000000);
        rd(12'h300);
        check("mask after reset", rdat, 32'h00000000);
        rd(12'h310);
        check("flags after reset", rdat, 32'h00000000);
    endtask

    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset_values();
        t_flags();
        t_links();
        t_mask();
        t_irq();
        t_mid_reset();
        complete_run();
    end
endmodule
